// ===== hw/readout_defs.svh
/*
  Constants of the pixel array readout sequencer: register offsets,
  field positions, reset values, window limits and counts.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef READOUT_DEFS_SVH
`define READOUT_DEFS_SVH
`define OFS_CTRL      6'h00
`define OFS_ORIENT    6'h01
`define OFS_XSTART    6'h02
`define OFS_XEND      6'h03
`define OFS_YSTART    6'h04
`define OFS_YEND      6'h05
`define OFS_ODDINC    6'h06
`define OFS_PEDESTAL  6'h07
`define OFS_EXPOSURE  6'h08
`define OFS_ROWLEN    6'h09
`define OFS_STATUS    6'h0A
`define CTRL_STREAM   0
`define CTRL_SNAP     1
`define CTRL_ROLLING  2
`define CTRL_LOCK     3
`define CTRL_CAMERGE  4
`define CTRL_CDBIN    5
`define CTRL_ROWBIN   6
`define ORIENT_MIRROR 14
`define ORIENT_FLIP   15
`define CTRL_RST      7'h0C
`define PED_RST       12'h0A8
`define ADDR_MIN      12'h006
`define COL_MAX       12'h905
`define ROW_MAX       12'h60D
`define ODD_RST       3'h1
`define EXP_RST       12'h010
`define ROWLEN_RST    12'h040
`define DIV3_MUL      11'h2AB
`define FIFO_DEPTH    16
`define PIX_W         12
`endif

// ===== hw/readout_pkg.sv
/*
  Types of the pixel array readout sequencer.
  Assumes readout_defs.svh on the include path.
*/
`include "readout_defs.svh"
package readout_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RUN    = 2'b01,
    ST_EXPOSE = 2'b11,
    ST_GREAD  = 2'b10
  } seq_state_e;
  typedef struct packed {
    logic [`PIX_W-1:0] pix_b;
    logic [`PIX_W-1:0] pix_a;
  } pix_pair_s;
  typedef struct packed {
    logic       wr;
    logic [5:0] idx;
  } bus_req_s;
endpackage

// ===== hw/pixel_array_readout_sequencer.sv
/*
  Pixel array readout sequencer with its output FIFO and AHB-Lite
  register slave. Assumes the array answers combinationally: pix_in
  holds the pair at col_addr while col_read is high, and hready is
  the slave's own hreadyout (single slave, zero wait states).
*/
`include "readout_defs.svh"
module readout_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// Operation
// - Every output pixel gets the 12-bit pedestal added, 168 at reset.
// - Pedestal writes count only while the lock bit, reset to one, is 0.
// - Rolling mode resets then reads each row, same interval per row.
// - Exposure changes take effect at a frame start, so frames stay uniform.
// - Global mode takes one frame and drives an external shutter.
// - The window is bounded by first/last column and row, starts at 6 min.
// - Mirror reverses columns, from last column plus one down to first plus one.
// - Flip reverses rows, from last row down to first row.
// - The readable Bayer order follows the mirror and flip bits.
// - Horizontal binning merges 2 or 3 same-color pixels, analog or digital.
// - Vertical binning merges 2 or 3 same-color rows in the analog path.
// - Skipping by 2 or 3 in both axes; row skipping shortens the frame.
// - Addresses go in pairs, odd increment after each pair, Gr-R first.
// - Subsampling factor is (1 + odd increment) / 2: 1, 2 or 3.
// - Column merge enables need an odd increment of 3 or 5.
// - Row binning needs its enable and a row odd increment of 3 or 5.
module pixel_array_readout_sequencer
  import readout_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Pixel array control
  output logic             row_rst,
  output logic [11:0]      row_rst_addr,
  output logic             row_rd,
  output logic [11:0]      row_rd_addr,
  output logic             row_merge,
  output logic             col_read,
  output logic [11:0]      col_addr,
  output logic             col_mirror,
  output logic             col_merge,
  input  wire pix_pair_s   pix_in,
  // Mechanical shutter
  output logic             global_rst,
  output logic             shutter_open,
  // Output pixel stream
  output logic             out_valid,
  input  wire logic        out_ready,
  output pix_pair_s        out_data
);
  seq_state_e  state_r;
  bus_req_s    req_r;
  logic [6:0]  ctrl_r;
  logic        snap_r;
  logic [1:0]  orient_r;
  logic [11:0] xs_r, xe_r, ys_r, ye_r, ped_r, exp_r, rowlen_r, exp_lat_r;
  logic [2:0]  xodd_r, yodd_r;
  logic [1:0]  pix_order_r;
  logic [11:0] slot_cnt_r, slot_idx_r, frame_cnt_r;
  logic        slot_start_r, rd_fin_r;
  logic [11:0] rst_row_r, rd_row_r;
  logic        rst_ph_r, rd_ph_r, rst_act_r, rd_act_r;
  logic [1:0]  grp_r;
  logic [13:0] acc_a_r, acc_b_r;
  logic        fifo_ready, push;
  pix_pair_s   push_data;
  logic [1:0]  xfac, yfac;
  logic        dbin, slot_end, first_col_ok;
  logic [11:0] col_step, first_row, first_col;
  logic [12:0] col_next;
  logic [12:0] rst_row_nxt, rd_row_nxt;

  // Factor from odd increment; other settings fall back to no subsampling
  function automatic logic [1:0] sub_fac(input logic [2:0] odd);
    case (odd)
      3'h3:    sub_fac = 2'h2;
      3'h5:    sub_fac = 2'h3;
      default: sub_fac = 2'h1;
    endcase
  endfunction
  // Next row of a pair walk; bit 12 flags the walk leaving the window
  function automatic logic [12:0] next_row(input logic [11:0] r,
      input logic ph, input logic [2:0] odd, input logic flip,
      input logic [11:0] lo, input logic [11:0] hi);
    logic [12:0] n;
    logic [12:0] st;
    st = ph ? {10'h000, odd} : 13'h0001;
    n  = flip ? ({1'b0, r} - st) : ({1'b0, r} + st);
    if (n[12] || (flip ? (n[11:0] < lo) : (n[11:0] > hi))) begin
      next_row = {1'b1, r};
    end else begin
      next_row = {1'b0, n[11:0]};
    end
  endfunction

  assign xfac      = sub_fac(xodd_r);
  assign yfac      = sub_fac(yodd_r);
  assign dbin      = ctrl_r[`CTRL_CDBIN] && (xfac != 2'h1);
  assign col_step  = dbin ? 12'h002 : {8'h00, 1'b0, xodd_r} + 12'h001;
  assign first_col = orient_r[0] ? xe_r + 12'h001 : xs_r;
  assign first_row = orient_r[1] ? ye_r : ys_r;
  assign col_next  = orient_r[0] ? {1'b0, col_addr} - {1'b0, col_step}
                                 : {1'b0, col_addr} + {1'b0, col_step};
  assign first_col_ok = orient_r[0]
      ? (!col_next[12] && col_next[11:0] >= xs_r + 12'h001)
      : (col_next[11:0] + 12'h001 <= xe_r);
  assign slot_end  = (slot_cnt_r >= rowlen_r) && !col_read;
  // Next rows of both pointers; bit 12 flags the end of the window
  assign rst_row_nxt = next_row(rst_row_r, rst_ph_r, yodd_r, orient_r[1],
                                ys_r, ye_r);
  assign rd_row_nxt  = next_row(rd_act_r ? rd_row_r : first_row,
                                rd_act_r ? rd_ph_r : 1'b0, yodd_r,
                                orient_r[1], ys_r, ye_r);

  // Bus slave: zero wait states, OKAY always, unmapped reads as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r     <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      req_r.wr  <= hsel && hready && htrans[1] && hwrite;
      req_r.idx <= haddr[7:2];
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:2])
          `OFS_CTRL:     hrdata <= {25'h0, ctrl_r[6:2], 1'b0, ctrl_r[0]};
          `OFS_ORIENT:   hrdata <= {16'h0, orient_r, 14'h0};
          `OFS_XSTART:   hrdata <= {20'h0, xs_r};
          `OFS_XEND:     hrdata <= {20'h0, xe_r};
          `OFS_YSTART:   hrdata <= {20'h0, ys_r};
          `OFS_YEND:     hrdata <= {20'h0, ye_r};
          `OFS_ODDINC:   hrdata <= {25'h0, yodd_r, 1'b0, xodd_r};
          `OFS_PEDESTAL: hrdata <= {20'h0, ped_r};
          `OFS_EXPOSURE: hrdata <= {20'h0, exp_r};
          `OFS_ROWLEN:   hrdata <= {20'h0, rowlen_r};
          `OFS_STATUS:   hrdata <= {frame_cnt_r, 16'h0, shutter_open,
                                    state_r != ST_IDLE, pix_order_r};
          default:       hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers; window clamped into the active array
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= `CTRL_RST;
      orient_r <= 2'h0;
      xs_r     <= `ADDR_MIN;
      xe_r     <= `COL_MAX;
      ys_r     <= `ADDR_MIN;
      ye_r     <= `ROW_MAX;
      xodd_r   <= `ODD_RST;
      yodd_r   <= `ODD_RST;
      ped_r    <= `PED_RST;
      exp_r    <= `EXP_RST;
      rowlen_r <= `ROWLEN_RST;
    end else if (req_r.wr) begin
      case (req_r.idx)
        `OFS_CTRL:   ctrl_r <= hwdata[6:0];
        `OFS_ORIENT: orient_r <= hwdata[`ORIENT_FLIP:`ORIENT_MIRROR];
        `OFS_XSTART: xs_r <= (hwdata[11:0] < `ADDR_MIN) ? `ADDR_MIN
                           : hwdata[11:0];
        `OFS_XEND:   xe_r <= (hwdata[11:0] > `COL_MAX) ? `COL_MAX
                           : hwdata[11:0];
        `OFS_YSTART: ys_r <= (hwdata[11:0] < `ADDR_MIN) ? `ADDR_MIN
                           : hwdata[11:0];
        `OFS_YEND:   ye_r <= (hwdata[11:0] > `ROW_MAX) ? `ROW_MAX
                           : hwdata[11:0];
        `OFS_ODDINC: begin
          xodd_r <= hwdata[2:0];
          yodd_r <= hwdata[6:4];
        end
        `OFS_PEDESTAL: begin
          if (!ctrl_r[`CTRL_LOCK]) begin
            ped_r <= hwdata[11:0];
          end
        end
        `OFS_EXPOSURE: exp_r <= (hwdata[11:0] == 12'h000) ? 12'h001
                              : hwdata[11:0];
        `OFS_ROWLEN:   rowlen_r <= hwdata[11:0];
        default: ;
      endcase
    end
  end

  // Snapshot trigger is a one-shot; a trigger during a frame is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= 1'b0;
    end else begin
      snap_r <= req_r.wr && (req_r.idx == `OFS_CTRL) && hwdata[`CTRL_SNAP];
    end
  end

  // Bayer phase and merge controls follow the settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_order_r <= 2'h0;
      col_mirror  <= 1'b0;
      col_merge   <= 1'b0;
      row_merge   <= 1'b0;
    end else begin
      pix_order_r <= orient_r;
      col_mirror  <= orient_r[0];
      col_merge   <= ctrl_r[`CTRL_CAMERGE] && (xfac != 2'h1);
      row_merge   <= ctrl_r[`CTRL_ROWBIN] && (yfac != 2'h1);
    end
  end

  // Row sequencer: reset pointer leads read pointer by exp_lat_r slots
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_IDLE;
      exp_lat_r    <= `EXP_RST;
      slot_cnt_r   <= 12'h000;
      slot_idx_r   <= 12'h000;
      slot_start_r <= 1'b0;
      frame_cnt_r  <= 12'h000;
      rst_row_r    <= 12'h000;
      rd_row_r     <= 12'h000;
      rst_ph_r     <= 1'b0;
      rd_ph_r      <= 1'b0;
      rst_act_r    <= 1'b0;
      rd_act_r     <= 1'b0;
      rd_fin_r     <= 1'b0;
      row_rst      <= 1'b0;
      row_rst_addr <= 12'h000;
      row_rd       <= 1'b0;
      row_rd_addr  <= 12'h000;
      col_read     <= 1'b0;
      col_addr     <= 12'h000;
      global_rst   <= 1'b0;
      shutter_open <= 1'b0;
    end else begin
      row_rst    <= 1'b0;
      row_rd     <= 1'b0;
      global_rst <= 1'b0;
      if (col_read && fifo_ready) begin
        if (first_col_ok) begin
          col_addr <= col_next[11:0];
        end else begin
          col_read <= 1'b0;
        end
      end
      case (state_r)
        ST_IDLE: begin
          slot_cnt_r <= 12'h000;
          slot_idx_r <= 12'h000;
          rd_fin_r   <= 1'b0;
          exp_lat_r  <= exp_r;
          if (ctrl_r[`CTRL_STREAM] && ctrl_r[`CTRL_ROLLING]) begin
            state_r      <= ST_RUN;
            rst_row_r    <= first_row;
            rst_ph_r     <= 1'b0;
            rst_act_r    <= 1'b1;
            rd_act_r     <= 1'b0;
            slot_start_r <= 1'b1;
          end else if (snap_r && !ctrl_r[`CTRL_ROLLING]) begin
            state_r      <= ST_EXPOSE;
            global_rst   <= 1'b1;
            shutter_open <= 1'b1;
          end
        end
        ST_EXPOSE: begin
          slot_cnt_r <= slot_cnt_r + 12'h001;
          if (slot_end) begin
            slot_cnt_r <= 12'h000;
            slot_idx_r <= slot_idx_r + 12'h001;
            if (slot_idx_r + 12'h001 >= exp_lat_r) begin
              shutter_open <= 1'b0;
              state_r      <= ST_GREAD;
              rd_row_r     <= first_row;
              rd_ph_r      <= 1'b0;
              rd_act_r     <= 1'b1;
              slot_start_r <= 1'b1;
            end
          end
        end
        ST_RUN, ST_GREAD: begin
          slot_cnt_r <= slot_cnt_r + 12'h001;
          if (slot_start_r) begin
            slot_start_r <= 1'b0;
            if (rst_act_r && state_r == ST_RUN) begin
              row_rst      <= 1'b1;
              row_rst_addr <= rst_row_r;
              {rst_act_r, rst_row_r} <= {~rst_row_nxt[12],
                                         rst_row_nxt[11:0]};
              rst_ph_r <= ~rst_ph_r;
            end
            if (rd_act_r || (state_r == ST_RUN && slot_idx_r == exp_lat_r)) begin
              row_rd      <= 1'b1;
              row_rd_addr <= rd_act_r ? rd_row_r : first_row;
              col_read    <= 1'b1;
              col_addr    <= first_col;
              {rd_fin_r, rd_row_r} <= rd_row_nxt;
              rd_act_r <= ~rd_row_nxt[12];
              rd_ph_r  <= rd_act_r ? ~rd_ph_r : 1'b1;
            end
          end else if (slot_end) begin
            slot_cnt_r   <= 12'h000;
            slot_idx_r   <= slot_idx_r + 12'h001;
            slot_start_r <= 1'b1;
            if (rd_fin_r) begin
              frame_cnt_r  <= frame_cnt_r + 12'h001;
              slot_start_r <= 1'b0;
              state_r      <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Digital binning and pedestal on the way into the FIFO
  logic [13:0] sum_a, sum_b;
  logic [23:0] div_a, div_b;
  logic [12:0] ped_a, ped_b;
  logic [11:0] bin_a, bin_b;
  assign sum_a = acc_a_r + {2'h0, pix_in.pix_a};
  assign sum_b = acc_b_r + {2'h0, pix_in.pix_b};
  assign div_a = sum_a * {3'h0, `DIV3_MUL};
  assign div_b = sum_b * {3'h0, `DIV3_MUL};
  always_comb begin
    bin_a = pix_in.pix_a;
    bin_b = pix_in.pix_b;
    if (dbin && xfac == 2'h2) begin
      bin_a = sum_a[12:1];
      bin_b = sum_b[12:1];
    end else if (dbin) begin
      bin_a = div_a[22:11];
      bin_b = div_b[22:11];
    end
  end
  assign ped_a = {1'b0, bin_a} + {1'b0, ped_r};
  assign ped_b = {1'b0, bin_b} + {1'b0, ped_r};
  // Saturate rather than wrap, so bright pixels stay bright
  assign push_data.pix_a = ped_a[12] ? 12'hFFF : ped_a[11:0];
  assign push_data.pix_b = ped_b[12] ? 12'hFFF : ped_b[11:0];
  assign push = col_read && fifo_ready
             && (!dbin || grp_r == xfac - 2'h1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grp_r   <= 2'h0;
      acc_a_r <= 14'h0000;
      acc_b_r <= 14'h0000;
    end else if (col_read && fifo_ready && dbin) begin
      if (grp_r == xfac - 2'h1) begin
        grp_r   <= 2'h0;
        acc_a_r <= 14'h0000;
        acc_b_r <= 14'h0000;
      end else begin
        grp_r   <= grp_r + 2'h1;
        acc_a_r <= sum_a;
        acc_b_r <= sum_b;
      end
    end else if (!col_read) begin
      grp_r   <= 2'h0;
      acc_a_r <= 14'h0000;
      acc_b_r <= 14'h0000;
    end
  end

  readout_fifo #(.WIDTH(2 * `PIX_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  a_ped_lock: assert property (@(posedge clk) disable iff (!rst_n)
    (req_r.wr && req_r.idx == `OFS_PEDESTAL && ctrl_r[`CTRL_LOCK])
    |=> $stable(ped_r)) else $error("pedestal changed while locked");
  a_ped_add: assert property (@(posedge clk) disable iff (!rst_n)
    (push && !dbin && {1'b0, pix_in.pix_a} + {1'b0, ped_r} < 13'h1000)
    |-> push_data.pix_a == pix_in.pix_a + ped_r)
    else $error("pedestal not added");
  a_order_map: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pix_order_r == $past(orient_r)) else $error("bayer order stale");
  a_win_min: assert property (@(posedge clk) disable iff (!rst_n)
    xs_r >= `ADDR_MIN && ys_r >= `ADDR_MIN) else $error("window below 6");
  a_mirror_start: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(col_read) && col_mirror |-> col_addr == xe_r + 12'h001)
    else $error("mirror start wrong");
  a_flip_start: assert property (@(posedge clk) disable iff (!rst_n)
    (row_rst && $past(state_r) == ST_RUN && $past(slot_idx_r) == 12'h000
     && orient_r[1]) |-> row_rst_addr == ye_r)
    else $error("flip start wrong");
  a_exp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_RUN && $past(state_r) == ST_RUN |-> $stable(exp_lat_r))
    else $error("exposure changed mid frame");
  a_shutter_seq: assert property (@(posedge clk) disable iff (!rst_n)
    global_rst |-> shutter_open ##1 !global_rst)
    else $error("shutter not opened with reset");
  a_row_merge: assert property (@(posedge clk) disable iff (!rst_n)
    row_merge |-> $past(yodd_r) == 3'h3 || $past(yodd_r) == 3'h5)
    else $error("row merge without 3 or 5");
endmodule

// ===== verification/pixel_array_model.sv
/*
  Pixel array stand-in: answers each column read with a coded pair.
  Assumes the sequencer's col_read, col_addr and col_mirror.
*/
module pixel_array_model
  import readout_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Column read
  input  wire logic        col_read,
  input  wire logic [11:0] col_addr,
  input  wire logic        col_mirror,
  output pix_pair_s        pix_in
);
  timeunit 1ns;
  timeprecision 1ps;
  pix_pair_s   last_r;
  logic [11:0] mate;
  // Partner column of the pair
  assign mate = col_mirror ? col_addr - 12'h001 : col_addr + 12'h001;
  // Off-read value flips each cycle so stale data never matches
  assign pix_in = col_read ? {12'(mate * 12'h0D3), 12'(col_addr * 12'h0D3)}
                           : ~last_r;
  always_ff @(posedge clk) begin
    last_r <= pix_in;
  end
endmodule

// ===== verification/test_pixel_array_readout_sequencer.sv
/*
  Testbench of the readout sequencer: registers, snapshot frames and
  rolling streaming. Assumes the array model beside the design.
*/
`include "readout_defs.svh"
module test_pixel_array_readout_sequencer
  import readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, seed, rd;
  logic        row_rst, row_rd, row_merge, col_read, col_mirror;
  logic        col_merge, global_rst, shutter_open, out_valid, out_ready;
  logic [11:0] row_rst_addr, row_rd_addr, col_addr, ped;
  pix_pair_s   pix_in, out_data;
  int          error_cnt, tests_run, cyc, open_n, exp_open, iv, ref_a;
  int          ref_v, lo_until;
  bit          ign, gmode, cm_exp, rm_exp;
  pix_pair_s   pq[$];
  logic [11:0] rq[$];
  int          rst_t[int];
  logic [31:0] rval[12] = '{`CTRL_RST, 0, `ADDR_MIN, `COL_MAX, `ADDR_MIN,
    `ROW_MAX, 32'h11, `PED_RST, `EXP_RST, `ROWLEN_RST, 0, 0};

  pixel_array_readout_sequencer i_pixel_array_readout_sequencer (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .row_rst,
    .row_rst_addr, .row_rd, .row_rd_addr, .row_merge, .col_read,
    .col_addr, .col_mirror, .col_merge, .pix_in, .global_rst,
    .shutter_open, .out_valid, .out_ready, .out_data);
  pixel_array_model i_pixel_array_model (
    .clk, .col_read, .col_addr, .col_mirror, .pix_in);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Coded pixel plus pedestal, clipped at full scale
  // Digital bin 2x averages a pixel with its same-color neighbour
  function automatic logic [11:0] px(int c, bit b = 1'b0);
    logic [12:0] s;
    s = {1'b0, 12'(c * 12'h0D3)};
    if (b) s = (s + {1'b0, 12'((c + 2) * 12'h0D3)}) >> 1;
    s = s + {1'b0, ped};
    return s[12] ? 12'hFFF : s[11:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] ix, input int d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ix, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rc(input logic [5:0] ix, input logic [31:0] exp);
    bus(1'b0, ix, 0);
    chk(rd, exp);
  endtask

  task automatic frame(input int x0, x1, y0, y1, xo, yo, ctl, ori);
    bus(1'b1, `OFS_XSTART, x0);
    bus(1'b1, `OFS_XEND, x1);
    bus(1'b1, `OFS_YSTART, y0);
    bus(1'b1, `OFS_YEND, y1);
    bus(1'b1, `OFS_ODDINC, (yo << 4) | xo);
    bus(1'b1, `OFS_ORIENT, ori << 14);
    bus(1'b1, `OFS_CTRL, ctl);
    cm_exp = ctl[4] && xo > 1;
    rm_exp = ctl[6] && yo > 1;
    // Rows in pairs, then the odd step
    // Windows span an even count of rows
    for (int r = ori[1] ? y1 : y0; ori[1] ? r >= y0 : r <= y1;
         r += ori[1] ? -(yo + 1) : yo + 1) begin
      rq.push_back(12'(r));
      rq.push_back(12'(ori[1] ? r - 1 : r + 1));
    end
    for (int k = 0; k < rq.size(); k++) begin
      if (ori[0])
        for (int c = x1 + 1; c > x0; c -= xo + 1) pq.push_back({px(c - 1), px(c)});
      else
        for (int c = x0; c <= x1; c += xo + 1)
          pq.push_back({px(c + 1, ctl[5]), px(c, ctl[5])});
    end
    bus(1'b1, `OFS_CTRL, ctl | 2);
    for (int k = 0; k < 20000 && pq.size() + rq.size() > 0; k++) @(posedge clk);
    chk(pq.size() + rq.size(), 0);
    $display("frame %0d-%0d x %0d-%0d done", x0, x1, y0, y1);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Random stalls on the output side, a long hold while lo_until runs
  always @(posedge clk) begin
    seed = xs();
    out_ready <= (seed[0] | seed[1] | ign) && cyc >= lo_until;
  end

  always @(posedge clk) begin
    cyc++;
    if (out_valid && out_ready && (!ign || pq.size() > 0))
      chk(out_data, pq.size() ? pq.pop_front() : ~out_data);
    if (row_rd && rq.size()) chk(row_rd_addr, rq.pop_front());
    if (row_rst && gmode) chk(row_rst, 0);
    if (col_read && gmode)
      chk({col_merge, row_merge}, {cm_exp, rm_exp});
    if (shutter_open) open_n++;
    else if (open_n > 0) begin
      chk(open_n, exp_open);
      open_n = 0;
    end
    if (row_rst) rst_t[row_rst_addr] = cyc;
    if (row_rd && !gmode && rst_t.exists(row_rd_addr)) begin
      iv = cyc - rst_t[row_rd_addr];
      if (row_rd_addr == 12'h006) ref_v = iv;
      else chk(iv, ref_v);
    end
  end

  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end

  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, out_ready} = '0;
    {ign, cm_exp, rm_exp, cyc, lo_until} = '0;
    hsize = 3'h2;
    seed = 55;
    gmode = 1'b1;
    ped = `PED_RST;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++)
      rc(i == 11 ? 6'h10 : 6'(i), rval[i]);
    bus(1'b1, `OFS_PEDESTAL, 32'h123);
    rc(`OFS_PEDESTAL, `PED_RST);
    bus(1'b1, `OFS_CTRL, 0);
    ped = 12'(xs());
    bus(1'b1, `OFS_PEDESTAL, ped);
    rc(`OFS_PEDESTAL, ped);
    bus(1'b1, `OFS_XSTART, 2);
    rc(`OFS_XSTART, 6);
    for (int f = 0; f < 4; f++) begin
      bus(1'b1, `OFS_ORIENT, f << 14);
      rc(`OFS_STATUS, f);
    end
    $display("register checks done");
    bus(1'b1, `OFS_EXPOSURE, 3);
    bus(1'b1, `OFS_ROWLEN, 8);
    exp_open = 3 * 9;
    frame(6, 13, 6, 9, 1, 1, 32'h10, 0);
    frame(6, 13, 6, 9, 1, 1, 0, 1);
    frame(6, 13, 6, 9, 1, 1, 0, 2);
    frame(6, 17, 6, 17, 3, 3, 32'h50, 0);
    frame(6, 17, 6, 17, 3, 3, 32'h20, 0);
    frame(6, 15, 6, 15, 5, 5, 0, 0);
    lo_until = cyc + 400;
    frame(6, 45, 6, 7, 1, 1, 0, 0);
    gmode = 1'b0;
    ign = 1'b1;
    // Streaming keeps going; only the first frame is queued
    frame(6, 13, 6, 9, 1, 1, 32'h05, 0);
    bus(1'b1, `OFS_EXPOSURE, 2);
    bus(1'b1, `OFS_CTRL, 32'h05);
    repeat (400) @(posedge clk);
    ref_a = ref_v;
    bus(1'b1, `OFS_EXPOSURE, 4);
    repeat (1200) @(posedge clk);
    chk(ref_v, 2 * ref_a);
    $display("rolling checks done");
    finish_test();
  end
endmodule
